// [core/iocs_decoder_regs.vh]
// Constants for the I/O chip-select decoder: ports, field positions,
// reset values and select codes.
// Assumes it is included by the decoder and by the bench; definitions only.
//
// Overview of operation
// - Upper mask bit gates compare of A15..A10
// - Lower mask codes 1-3 ignore 1-3 low bits
// - Lower mask code 100 ignores A03..A00
// - Bus location bit routes programmable select
// - Fast disk: first compatible, later compressed
// - Primary/secondary bit picks disk addresses, floppy ones only with ide_mode
// - Fast coprocessor bit gives 16-bit timing
// - Prevent bit set first blocks password lock
// - Existing lock unaffected by prevent bit
// - Disk disable suppresses codes 0C, 0D
// - Floppy disable suppresses codes 08-0B
// - 16-bit programmable address register, read/write
// - Three-digit ports ignore A15..A10
// - Each select shown as 5-bit code
// - Other decodes override programmable select
// - Serial A wins over serial B
// - Floppy control port gives 0A or 0B
// - Disk control includes 3F7 only conditionally
// - Ports 00E0-00FF give coprocessor code 02
// - Programmable select only while enabled
`ifndef IOCS_DECODER_REGS_VH
`define IOCS_DECODER_REGS_VH

// ----------------------------------------------------------------
// Register ports
// ----------------------------------------------------------------
`define IOCS_PORT_CFG 16'h2872
`define IOCS_PORT_PADDR 16'h3072
`define IOCS_PORT_LOCK 16'h0092
`define IOCS_LOCK_BIT 3
`define IOCS_CFG_RST 16'h0000
`define IOCS_PADDR_RST 16'h0000
`define IOCS_CFG_USED 16'hFFDF

// ----------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------
`define IOCS_F_FLP_DIS 0
`define IOCS_F_HD_DIS 1
`define IOCS_F_PW_PREV 2
`define IOCS_F_COP_FAST 3
`define IOCS_F_PRISEC 4
`define IOCS_F_DISK_FAST 6
`define IOCS_F_BUS_LOC 7
`define IOCS_F_LMASK_LO 8
`define IOCS_F_LMASK_HI 10
`define IOCS_F_UMASK 11
`define IOCS_F_PEN 12

// ----------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------
`define IOCS_CS_KBD 5'h01
`define IOCS_CS_COP 5'h02
`define IOCS_CS_PMC0 5'h03
`define IOCS_CS_RTC_ALE 5'h05
`define IOCS_CS_RTC_WR 5'h06
`define IOCS_CS_RTC_RD 5'h07
`define IOCS_CS_FLP_OP 5'h08
`define IOCS_CS_FLP 5'h09
`define IOCS_CS_FLP_CTL 5'h0A
`define IOCS_CS_FLP_HD_CTL 5'h0B
`define IOCS_CS_HD 5'h0C
`define IOCS_CS_HD_CTL 5'h0D
`define IOCS_CS_SER_A 5'h0E
`define IOCS_CS_SER_B 5'h10
`define IOCS_CS_PROG 5'h11
`define IOCS_CS_FLUSH 5'h13
`define IOCS_CS_PMC1 5'h17
`define IOCS_CS_FLP_ST 5'h18
`define IOCS_CS_FLP_B 5'h19
`define IOCS_CS_NONE 5'h00

// ----------------------------------------------------------------
// Fixed addresses (three-digit ones are 10 bits wide, except the 12-bit IOCS_A_COP_HI)
// ----------------------------------------------------------------
`define IOCS_A_KBD_LO 10'h060
`define IOCS_A_KBD_HI 10'h06E
`define IOCS_A_COP_HI 12'h00E
`define IOCS_A_PMC0 16'h7072
`define IOCS_A_PMC1 16'h7872
`define IOCS_A_FLUSH 16'hF872
`define IOCS_A_RTC_IDX 10'h070
`define IOCS_A_RTC_DAT 10'h071
`define IOCS_A_FLP_PRI 10'h3F0
`define IOCS_A_FLP_SEC 10'h370
`define IOCS_A_HD_PRI 10'h1F0
`define IOCS_A_HD_SEC 10'h170
`define IOCS_A_SER_1 10'h3F8
`define IOCS_A_SER_2 10'h2F8
`define IOCS_A_SER_3 10'h3E8
`define IOCS_A_SER_4 10'h2E8
`define IOCS_OFF_FLP_OP 3'h2
`define IOCS_OFF_FLP_B 3'h3
`define IOCS_OFF_DSK_CTL 3'h6
`define IOCS_OFF_FLP_CTL 3'h7
`define IOCS_OFF_HD_CTL 10'h200

`endif

// [core/iocs_decoder.v]
// I/O chip-select decoder with its three configuration ports.
// Assumes host I/O strobes and address arrive from pins, asynchronous
// to clk_sys; serial selects and IDE mode come from logic on clk_sys.
`timescale 1ns/10ps
`include "iocs_decoder_regs.vh"

module iocs_decoder #(
  parameter AW = 16,
  parameter DW = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire [AW-1:0] io_addr,
  input wire [DW-1:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  input wire [2:0] ser_a_sel,
  input wire [2:0] ser_b_sel,
  input wire ide_mode,
  output reg [DW-1:0] io_rdata,
  output reg io_rdata_oe,
  output reg [4:0] select_code_out,
  output reg select_valid,
  output reg prog_select_bus_loc,
  output reg coproc_16bit,
  output reg disk_fast_cycle,
  output reg disk_select_hold,
  output reg password_locked
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [AW-1:0] addr_s1_q;
  reg [AW-1:0] addr_q;
  reg [DW-1:0] wdata_s1_q;
  reg [DW-1:0] wdata_q;
  reg [1:0] strb_s1_q;
  reg [1:0] strb_q;
  reg [1:0] strb_prev_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_s1_q <= {AW{1'b0}};
      addr_q <= {AW{1'b0}};
      wdata_s1_q <= {DW{1'b0}};
      wdata_q <= {DW{1'b0}};
      strb_s1_q <= 2'b00;
      strb_q <= 2'b00;
      strb_prev_q <= 2'b00;
    end else begin
      addr_s1_q <= io_addr;
      addr_q <= addr_s1_q;
      wdata_s1_q <= io_wdata;
      wdata_q <= wdata_s1_q;
      strb_s1_q <= {io_wr, io_rd};
      strb_q <= strb_s1_q;
      strb_prev_q <= strb_q;
    end
  end

  wire rd_act = strb_q[0];
  wire wr_act = strb_q[1];
  wire cyc_act = rd_act | wr_act;
  wire cyc_start = cyc_act & ~(strb_prev_q[0] | strb_prev_q[1]);
  wire wr_start = wr_act & ~strb_prev_q[1];
  wire [9:0] a10 = addr_q[9:0];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [DW-1:0] cfg_q;
  reg [DW-1:0] paddr_q;
  reg lock_q;

  wire hit_cfg = addr_q == `IOCS_PORT_CFG;
  wire hit_paddr = addr_q == `IOCS_PORT_PADDR;
  wire hit_lock = addr_q == `IOCS_PORT_LOCK;

  wire flp_dis = cfg_q[`IOCS_F_FLP_DIS];
  wire hd_dis = cfg_q[`IOCS_F_HD_DIS];
  wire pw_prev = cfg_q[`IOCS_F_PW_PREV];
  wire cop_fast = cfg_q[`IOCS_F_COP_FAST];
  wire prisec = cfg_q[`IOCS_F_PRISEC];
  wire disk_fast = cfg_q[`IOCS_F_DISK_FAST];
  wire bus_loc = cfg_q[`IOCS_F_BUS_LOC];
  wire [2:0] lmask = cfg_q[`IOCS_F_LMASK_HI:`IOCS_F_LMASK_LO];
  wire umask = cfg_q[`IOCS_F_UMASK];
  wire pen = cfg_q[`IOCS_F_PEN];

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_q <= `IOCS_CFG_RST;
      paddr_q <= `IOCS_PADDR_RST;
      lock_q <= 1'b0;
    end else begin
      if (wr_start && hit_cfg) begin
        cfg_q <= wdata_q & `IOCS_CFG_USED;
      end
      if (wr_start && hit_paddr) begin
        paddr_q <= wdata_q;
      end
      if (wr_start && hit_lock && wdata_q[`IOCS_LOCK_BIT] && !pw_prev) begin
        lock_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Programmable select compare
  // ----------------------------------------------------------------
  reg [3:0] low_ign;

  always @* begin
    case (lmask)
      3'b000: low_ign = 4'h0;
      3'b001: low_ign = 4'h1;
      3'b010: low_ign = 4'h3;
      3'b011: low_ign = 4'h7;
      3'b100: low_ign = 4'hF;
      default: low_ign = 4'h0;
    endcase
  end

  wire [15:0] prog_cmp = {{6{umask}}, 6'h3F, ~low_ign};
  wire prog_hit = pen && (((addr_q ^ paddr_q) & prog_cmp) == 16'h0000);

  // ----------------------------------------------------------------
  // Fixed decodes
  // ----------------------------------------------------------------
  function ser_match;
    input [2:0] sel;
    input [9:0] a;
    begin
      case (sel)
        3'b001: ser_match = a[9:3] == `IOCS_A_SER_1 >> 3;
        3'b010: ser_match = a[9:3] == `IOCS_A_SER_2 >> 3;
        3'b011: ser_match = a[9:3] == `IOCS_A_SER_3 >> 3;
        3'b100: ser_match = a[9:3] == `IOCS_A_SER_4 >> 3;
        default: ser_match = 1'b0;
      endcase
    end
  endfunction

  wire flp_sec = prisec & ide_mode;
  wire [9:0] flp_base = flp_sec ? `IOCS_A_FLP_SEC : `IOCS_A_FLP_PRI;
  wire [9:0] hd_base = prisec ? `IOCS_A_HD_SEC : `IOCS_A_HD_PRI;
  wire in_flp = a10[9:3] == flp_base[9:3];
  wire in_hd = a10[9:3] == hd_base[9:3];
  wire [2:0] lo3 = a10[2:0];

  wire kbd_hit = (a10 >= `IOCS_A_KBD_LO) && (a10 <= `IOCS_A_KBD_HI) && !a10[0];
  wire cop_hit = addr_q[15:4] >= `IOCS_A_COP_HI && addr_q[15:5] == 11'h007;
  wire rtc_idx = a10 == `IOCS_A_RTC_IDX;
  wire rtc_dat = a10 == `IOCS_A_RTC_DAT;
  wire flp_op = in_flp && lo3 == `IOCS_OFF_FLP_OP;
  wire flp_st = in_flp && lo3[2:1] == 2'b00;
  wire flp_b = in_flp && lo3 == `IOCS_OFF_FLP_B;
  wire flp_fifo = in_flp && lo3[2:1] == 2'b10;
  wire flp_ctl = a10 == (flp_base | {7'h00, `IOCS_OFF_FLP_CTL});
  wire hd_ctl7 = a10 == (hd_base + `IOCS_OFF_HD_CTL + {7'h00, `IOCS_OFF_FLP_CTL});
  wire hd_ctl6 = a10 == (hd_base + `IOCS_OFF_HD_CTL + {7'h00, `IOCS_OFF_DSK_CTL});
  wire hd_data = in_hd && lo3 == 3'h0;
  wire ser_a = ser_match(ser_a_sel, a10);
  wire ser_b = ser_match(ser_b_sel, a10);

  // ----------------------------------------------------------------
  // Priority encode of the select code
  // ----------------------------------------------------------------
  reg [4:0] code_d;
  reg hit_d;

  always @* begin
    code_d = `IOCS_CS_NONE;
    hit_d = 1'b1;
    if (kbd_hit) begin
      code_d = `IOCS_CS_KBD;
    end else if (cop_hit) begin
      code_d = `IOCS_CS_COP;
    end else if (addr_q == `IOCS_A_PMC0) begin
      code_d = `IOCS_CS_PMC0;
    end else if (addr_q == `IOCS_A_PMC1) begin
      code_d = `IOCS_CS_PMC1;
    end else if (addr_q == `IOCS_A_FLUSH) begin
      code_d = `IOCS_CS_FLUSH;
    end else if (rtc_idx && wr_act) begin
      code_d = `IOCS_CS_RTC_ALE;
    end else if (rtc_dat) begin
      code_d = wr_act ? `IOCS_CS_RTC_WR : `IOCS_CS_RTC_RD;
    end else if (!flp_dis && flp_op) begin
      code_d = `IOCS_CS_FLP_OP;
    end else if (!flp_dis && flp_fifo) begin
      code_d = `IOCS_CS_FLP;
    end else if (!flp_dis && flp_st) begin
      code_d = `IOCS_CS_FLP_ST;
    end else if (!flp_dis && flp_b) begin
      code_d = `IOCS_CS_FLP_B;
    end else if (!flp_dis && flp_ctl) begin
      code_d = hd_dis ? `IOCS_CS_FLP_CTL : `IOCS_CS_FLP_HD_CTL;
    end else if (!hd_dis && in_hd) begin
      code_d = `IOCS_CS_HD;
    end else if (!hd_dis && (hd_ctl6 || (hd_ctl7 && flp_dis))) begin
      code_d = `IOCS_CS_HD_CTL;
    end else if (ser_a) begin
      code_d = `IOCS_CS_SER_A;
    end else if (ser_b) begin
      code_d = `IOCS_CS_SER_B;
    end else if (prog_hit && !hit_cfg && !hit_paddr) begin
      code_d = `IOCS_CS_PROG;
    end else begin
      hit_d = 1'b0;
    end
  end

  wire prog_sel = code_d == `IOCS_CS_PROG;

  // ----------------------------------------------------------------
  // Fast disk sequencing
  // ----------------------------------------------------------------
  reg first_done_q;
  reg cyc_fast_q;
  wire disk_data_cyc = !hd_dis && hd_data;

  // Speed of the current cycle, fixed at its start
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyc_fast_q <= 1'b0;
    end else if (cyc_start) begin
      cyc_fast_q <= disk_fast && first_done_q && disk_data_cyc;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_done_q <= 1'b0;
    end else if (!disk_fast) begin
      first_done_q <= 1'b0;
    end else if (cyc_start && disk_data_cyc) begin
      first_done_q <= 1'b1;
    end else if (cyc_start && !hd_dis && (in_hd || hd_ctl6)) begin
      first_done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      select_code_out <= `IOCS_CS_NONE;
      select_valid <= 1'b0;
      prog_select_bus_loc <= 1'b0;
      coproc_16bit <= 1'b0;
      disk_fast_cycle <= 1'b0;
      disk_select_hold <= 1'b0;
      password_locked <= 1'b0;
      io_rdata <= {DW{1'b0}};
      io_rdata_oe <= 1'b0;
    end else begin
      select_code_out <= (cyc_act && hit_d) ? code_d : `IOCS_CS_NONE;
      select_valid <= cyc_act && hit_d;
      prog_select_bus_loc <= cyc_act && prog_sel && bus_loc;
      coproc_16bit <= cyc_act && cop_hit && cop_fast;
      disk_fast_cycle <= cyc_act && disk_data_cyc && disk_fast && cyc_fast_q &&
                         !cyc_start;
      disk_select_hold <= disk_fast && first_done_q;
      password_locked <= lock_q;
      io_rdata_oe <= rd_act && (hit_cfg || hit_paddr);
      if (rd_act && hit_cfg) begin
        io_rdata <= cfg_q;
      end else if (rd_act && hit_paddr) begin
        io_rdata <= paddr_q;
      end else begin
        io_rdata <= {DW{1'b0}};
      end
    end
  end

endmodule // iocs_decoder

// [tb/iocs_decoder_checker.sv]
// Assertions on the I/O chip-select decoder ports.
// Bound to iocs_decoder; sees only its ports.
`timescale 1ns/10ps
`include "iocs_decoder_regs.vh"
module iocs_decoder_checker (
  input wire clk_sys,
  input wire rst,
  input wire [15:0] io_addr,
  input wire [15:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  input wire io_rdata_oe,
  input wire [2:0] ser_a_sel,
  input wire [2:0] ser_b_sel,
  input wire [4:0] select_code_out,
  input wire select_valid,
  input wire prog_select_bus_loc,
  input wire coproc_16bit,
  input wire password_locked
);
  // ---
  // Settled cycle and config shadow
  // ---
  reg [2:0] hold_q;
  reg [17:0] last_q;
  reg [15:0] cfg_q;
  wire st = io_rd | io_wr;
  wire [17:0] now = {io_wr, io_rd, io_addr & {16{st}}};
  wire ok = (hold_q > 3'd3) && (now == last_q);
  wire act = ok & st;
  wire ps = cfg_q[`IOCS_F_PRISEC];
  wire p37 = act && io_addr[9:0] == 10'h3F7 && !ps;
  wire [4:0] cs = select_code_out;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_q <= 3'd0;
      last_q <= 18'h00000;
      cfg_q <= 16'h0000;
    end else begin
      last_q <= now;
      if (now != last_q)
        hold_q <= 3'd0;
      else if (hold_q != 3'd7)
        hold_q <= hold_q + 3'd1;
      if (act && io_wr && io_addr == `IOCS_PORT_CFG)
        cfg_q <= io_wdata & `IOCS_CFG_USED;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  idle_quiet_a: assert property (ok && !st |-> !select_valid)
    else $error("select while idle");
  cop_code_a: assert property (act && io_addr[15:5] == 11'h007 |-> cs == `IOCS_CS_COP)
    else $error("coprocessor code wrong");
  cop_timing_a: assert property (act && cs == `IOCS_CS_COP
    |-> coproc_16bit == cfg_q[`IOCS_F_COP_FAST]) else $error("coprocessor timing wrong");
  hd_select_a: assert property (act && io_addr[9:3] == (ps ? 7'h2E : 7'h3E)
    |-> (cs == `IOCS_CS_HD) == !cfg_q[`IOCS_F_HD_DIS]) else $error("disk code wrong");
  flp_ctl_a: assert property (p37 && !cfg_q[`IOCS_F_FLP_DIS]
    |-> cs == (cfg_q[`IOCS_F_HD_DIS] ? 5'h0A : 5'h0B)) else $error("floppy control wrong");
  hd_ctl_a: assert property (p37 && cfg_q[`IOCS_F_FLP_DIS]
    && !cfg_q[`IOCS_F_HD_DIS] |-> cs == `IOCS_CS_HD_CTL) else $error("disk control wrong");
  ser_prio_a: assert property (act && ser_a_sel == 3'd1 && ser_b_sel == 3'd1
    && io_addr[9:3] == 7'h7F |-> cs == `IOCS_CS_SER_A) else $error("serial priority wrong");
  lock_kept_a: assert property (password_locked |=> password_locked)
    else $error("lock cleared");
  loc_code_a: assert property (prog_select_bus_loc
    |-> cs == `IOCS_CS_PROG && cfg_q[`IOCS_F_BUS_LOC]) else $error("bus location wrong");
  rdata_oe_a: assert property (act && io_rd && (io_addr == `IOCS_PORT_CFG
    || io_addr == `IOCS_PORT_PADDR) |-> io_rdata_oe) else $error("read enable missing");
  valid_code_a: assert property (act |-> select_valid == (cs != `IOCS_CS_NONE))
    else $error("select valid wrong");
  cover property (act && cs == `IOCS_CS_PROG);
  cover property (act && ser_a_sel == ser_b_sel && cs == `IOCS_CS_SER_A);
  cover property (password_locked && cfg_q[`IOCS_F_PW_PREV]);
endmodule // iocs_decoder_checker

bind iocs_decoder iocs_decoder_checker u_chk (.clk_sys, .rst, .io_addr, .io_wdata, .io_rd,
  .io_wr, .io_rdata_oe, .ser_a_sel, .ser_b_sel, .select_code_out, .select_valid,
  .prog_select_bus_loc,
  .coproc_16bit, .password_locked);

// [tb/iocs_host_model.sv]
// Host I/O master: one read or write cycle per call of run.
// Assumes outputs settle within 8 clocks of a strobe.
`timescale 1ns/10ps
module iocs_host_model (
  input wire clk_sys,
  input wire [4:0] select_code_out,
  input wire [15:0] io_rdata,
  input wire [3:0] flags,
  output logic [15:0] io_addr,
  output logic [15:0] io_wdata,
  output logic io_rd,
  output logic io_wr
);
  logic [4:0] cs_seen;
  logic [15:0] rd_seen;
  logic [15:0] flags_seen;
  initial begin
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
  end
  // ---
  // Address leads strobe by 2 clocks; released lines show the inverse
  // ---
  task automatic run(input logic w, input logic [15:0] a, input logic [15:0] d);
    io_addr <= a;
    io_wdata <= d;
    repeat (2) @(posedge clk_sys);
    io_rd <= ~w;
    io_wr <= w;
    repeat (8) @(posedge clk_sys);
    cs_seen = select_code_out;
    rd_seen = io_rdata;
    flags_seen = {12'h000, flags};
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    repeat (6) @(posedge clk_sys);
    io_addr <= ~a;
    io_wdata <= ~d;
    @(posedge clk_sys);
  endtask
endmodule // iocs_host_model

// [tb/tb_iocs_decoder.sv]
// Testbench of the I/O chip-select decoder.
// Host cycles come from iocs_host_model; checker is bound.
`timescale 1ns/10ps
`include "iocs_decoder_regs.vh"
module tb_iocs_decoder;
  logic clk_sys;
  logic rst;
  logic [2:0] ser_a_sel;
  logic [2:0] ser_b_sel;
  logic ide_mode;
  wire [15:0] io_addr;
  wire [15:0] io_wdata;
  wire io_rd;
  wire io_wr;
  wire [15:0] io_rdata;
  wire [4:0] select_code_out;
  wire prog_select_bus_loc;
  wire coproc_16bit;
  wire disk_fast_cycle;
  wire disk_select_hold;
  wire password_locked;
  int failures = 0;
  int total_checks = 0;
  iocs_decoder DUT (.clk_sys, .rst, .io_addr, .io_wdata, .io_rd, .io_wr, .ser_a_sel,
    .ser_b_sel, .ide_mode, .io_rdata, .io_rdata_oe(), .select_code_out, .select_valid(),
    .prog_select_bus_loc, .coproc_16bit, .disk_fast_cycle, .disk_select_hold,
    .password_locked);
  iocs_host_model host (.clk_sys, .select_code_out, .io_rdata, .io_addr, .io_wdata, .io_rd,
    .io_wr, .flags({disk_select_hold, disk_fast_cycle, prog_select_bus_loc, coproc_16bit}));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // Bit 16 of a marks a write cycle
  task automatic dec(input logic [15:0] c, input logic [16:0] a, input logic [4:0] e);
    host.run(1'b1, `IOCS_PORT_CFG, c);
    host.run(a[16], a[15:0], 16'h0000);
    chk({11'h000, host.cs_seen}, {11'h000, e});
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_regs;
    host.run(1'b0, `IOCS_PORT_CFG, 16'h0000);
    chk(host.rd_seen, `IOCS_CFG_RST);
    host.run(1'b1, `IOCS_PORT_CFG, 16'hFFFF);
    host.run(1'b1, `IOCS_PORT_PADDR, 16'hA5C3);
    host.run(1'b0, `IOCS_PORT_CFG, 16'h0000);
    chk(host.rd_seen, `IOCS_CFG_USED);
    host.run(1'b0, `IOCS_PORT_PADDR, 16'h0000);
    chk(host.rd_seen, 16'hA5C3);
  endtask
  task automatic t_fixed;
    dec(16'h0000, 17'h00060, 5'h01);
    dec(16'h0008, 17'h000FF, 5'h02);
    chk(host.flags_seen, 16'h0001);
    dec(16'h0000, 17'h000E0, 5'h02);
    chk(host.flags_seen, 16'h0000);
    dec(16'h0000, 17'h010E0, 5'h00);
    dec(16'h0000, 17'h10070, 5'h05);
    dec(16'h0000, 17'h10071, 5'h06);
    dec(16'h0000, 17'h00071, 5'h07);
    dec(16'h0000, 17'h17072, 5'h03);
    dec(16'h0000, 17'h17872, 5'h17);
    dec(16'h0000, 17'h003F0, 5'h18);
    dec(16'h0000, 17'h003F3, 5'h19);
    dec(16'h0000, 17'h003F5, 5'h09);
    dec(16'h0000, 17'h1F872, 5'h13);
    dec(16'h0000, 17'h0FBF2, 5'h08);
    dec(16'h0000, 17'h003F7, 5'h0B);
    dec(16'h0000, 17'h003F6, 5'h0D);
    dec(16'h0000, 17'h00300, 5'h00);
  endtask
  task automatic t_disk;
    ide_mode <= 1'b1;
    dec(16'h0010, 17'h00177, 5'h0C);
    dec(16'h0010, 17'h00377, 5'h0B);
    ide_mode <= 1'b0;
    dec(16'h0010, 17'h00372, 5'h00);
    dec(16'h0001, 17'h003F7, 5'h0D);
    dec(16'h0001, 17'h003F2, 5'h00);
    dec(16'h0002, 17'h003F7, 5'h0A);
    dec(16'h0002, 17'h001F0, 5'h00);
  endtask
  task automatic t_prog;
    host.run(1'b1, `IOCS_PORT_PADDR, 16'h0234);
    dec(16'h1000, 17'h0FE34, 5'h11);
    dec(16'h1800, 17'h0FE34, 5'h00);
    dec(16'h1100, 17'h00235, 5'h11);
    dec(16'h1100, 17'h00236, 5'h00);
    dec(16'h1200, 17'h00237, 5'h11);
    dec(16'h1300, 17'h00231, 5'h11);
    dec(16'h1400, 17'h0023F, 5'h11);
    dec(16'h0000, 17'h00234, 5'h00);
    dec(16'h1080, 17'h00234, 5'h11);
    chk(host.flags_seen, 16'h0002);
    host.run(1'b1, `IOCS_PORT_PADDR, 16'h01F0);
    dec(16'h1000, 17'h001F0, 5'h0C);
  endtask
  task automatic t_ser;
    ser_a_sel <= 3'd1;
    ser_b_sel <= 3'd1;
    dec(16'h0000, 17'h003F8, 5'h0E);
    ser_a_sel <= 3'd0;
    dec(16'h0000, 17'h003FF, 5'h10);
    ser_b_sel <= 3'd0;
  endtask
  task automatic t_fast;
    dec(16'h0040, 17'h001F0, 5'h0C);
    chk(host.flags_seen & 16'h0004, 16'h0000);
    host.run(1'b0, 16'h01F0, 16'h0000);
    chk(host.flags_seen & 16'h000C, 16'h000C);
    dec(16'h0000, 17'h001F0, 5'h0C);
    host.run(1'b0, 16'h01F0, 16'h0000);
    chk(host.flags_seen & 16'h000C, 16'h0000);
  endtask
  task automatic t_lock;
    host.run(1'b1, `IOCS_PORT_CFG, 16'h0004);
    host.run(1'b1, `IOCS_PORT_LOCK, 16'h0008);
    chk({15'h0000, password_locked}, 16'h0000);
    host.run(1'b1, `IOCS_PORT_CFG, 16'h0000);
    host.run(1'b1, `IOCS_PORT_LOCK, 16'h0008);
    host.run(1'b1, `IOCS_PORT_CFG, 16'h0004);
    host.run(1'b1, `IOCS_PORT_LOCK, 16'h0000);
    chk({15'h0000, password_locked}, 16'h0001);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    ser_a_sel = 3'd0;
    ser_b_sel = 3'd0;
    ide_mode = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_fixed();
    t_disk();
    t_prog();
    t_ser();
    t_fast();
    t_lock();
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule // tb_iocs_decoder
